// ---- rtl/stc_pkg.sv ----
package stc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry and register offsets
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CNT_LOW = 8'h04;
  localparam logic [7:0] OFF_CNT_HIGH = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CTRL = 8'h10;
  localparam logic [7:0] OFF_CPU_IRQ = 8'h14;
  localparam logic [7:0] OFF_CH_CTRL = 8'h20;
  localparam logic [7:0] OFF_CH_VAL = 8'h30;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DIV_LSB = 2;
  localparam int CTRL_SPD_LSB = 4;
  localparam int FLAG_TC_BIT = 0;
  localparam int FLAG_CH_LSB = 1;
  localparam int IRQC_MASK_BIT = 0;
  localparam int IRQC_EN_BIT = 1;
  localparam int CHC_CMP_BIT = 0;
  localparam int CHC_EDGE_LSB = 1;
  localparam int CHC_ACT_LSB = 3;
  localparam int CHC_IM_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and constants
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [1:0] IRQC_RST = 2'h0;
  localparam logic [5:0] CHC_RST = 6'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [6:0] DIV_LIM_1 = 7'h00;
  localparam logic [6:0] DIV_LIM_8 = 7'h07;
  localparam logic [6:0] DIV_LIM_32 = 7'h1F;
  localparam logic [6:0] DIV_LIM_128 = 7'h7F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    STC_STOP = 2'b00,
    STC_FREE = 2'b01,
    STC_MODULO = 2'b10,
    STC_UPDOWN = 2'b11
  } stc_run_mode_t;

  typedef enum logic [1:0] {
    STC_DIR_UP = 2'b01,
    STC_DIR_DOWN = 2'b10
  } stc_dir_t;

  typedef enum logic [1:0] {
    STC_ACT_SET = 2'b00,
    STC_ACT_CLR = 2'b01,
    STC_ACT_TGL = 2'b10,
    STC_ACT_HOLD = 2'b11
  } stc_cmp_act_t;

endpackage

// ---- rtl/stc_tick_gen.sv ----
`timescale 1ns/100ps
module stc_tick_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] tick_speed_select,
  input wire logic [1:0] tick_prescale_select,
  output logic tick
);
  import stc_pkg::*;

  logic [6:0] spd_cnt_reg, spd_cnt_next;
  logic [6:0] div_cnt_reg, div_cnt_next;
  logic tick_reg, tick_next;
  logic [6:0] spd_lim, div_lim;
  logic spd_tick;

  // Speed stage then prescale stage; system clock itself untouched
  always_comb begin
    spd_lim = 7'((8'h01 << tick_speed_select) - 8'h01);
    case (tick_prescale_select)
      2'b00: div_lim = DIV_LIM_1;
      2'b01: div_lim = DIV_LIM_8;
      2'b10: div_lim = DIV_LIM_32;
      default: div_lim = DIV_LIM_128;
    endcase
    spd_tick = (spd_cnt_reg >= spd_lim);
    spd_cnt_next = spd_tick ? 7'h00 : 7'(spd_cnt_reg + 7'h01);
    div_cnt_next = div_cnt_reg;
    tick_next = 1'b0;
    if (spd_tick) begin
      tick_next = (div_cnt_reg >= div_lim);
      div_cnt_next = tick_next ? 7'h00 : 7'(div_cnt_reg + 7'h01);
    end
  end

  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spd_cnt_reg <= 7'h00;
      div_cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else begin
      spd_cnt_reg <= spd_cnt_next;
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TICK_EVERY_CYCLE: assert property (
    (tick_speed_select == 3'h0 && tick_prescale_select == 2'b00)[*3]
    |-> tick_reg)
    else $error("tick missing at divide by one");
  AST_TICK_SPACING_8: assert property (
    (tick_speed_select == 3'h0 && tick_prescale_select == 2'b01 && tick_reg)
    ##1 (tick_prescale_select == 2'b01 && tick_speed_select == 3'h0)[*6]
    |-> !tick_reg)
    else $error("prescale of eight ticked early");

endmodule

// ---- rtl/stc_timer.sv ----
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module stc_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [stc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [stc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [stc_pkg::NUM_CH-1:0] ch_in,
  output logic [stc_pkg::NUM_CH-1:0] ch_out,
  output logic [stc_pkg::NUM_CH-1:0] ch_oe,
  output logic timer_irq
);
  import stc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic wr_fire, ar_fire, wr_lane0;
  logic [6:0] ctrl_reg, ctrl_next;
  logic [1:0] irqc_reg, irqc_next;
  logic [7:0] hi_latch_reg, hi_latch_next;
  logic [3:0] flags_reg, flags_next, flag_set, flag_clr;
  logic cpu_flag_reg, cpu_flag_next;
  logic timer_irq_reg, timer_irq_next;
  logic [15:0] cnt_reg, cnt_next;
  stc_dir_t dir_reg, dir_next;
  stc_run_mode_t run_mode;
  logic tick, tick_run, clr_cnt, tc_evt, cpu_set;
  logic [NUM_CH-1:0] ch_meta_reg, ch_sync_reg, ch_prev_reg;
  logic [NUM_CH-1:0] ch_evt, ch_im, ch_cmp;
  logic [5:0] chc_reg [NUM_CH];
  logic [15:0] val_reg [NUM_CH];
  logic pin_reg [NUM_CH];

  // Known register addresses
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a == OFF_CTRL || a == OFF_CNT_LOW || a == OFF_CNT_HIGH) begin
      hit = 1'b1;
    end else if (a == OFF_FLAGS || a == OFF_IRQ_CTRL) begin
      hit = 1'b1;
    end else if (a == OFF_CPU_IRQ) begin
      hit = 1'b1;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (a == 8'(OFF_CH_CTRL + 4 * i) || a == 8'(OFF_CH_VAL + 4 * i)) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_lane0 = wr_fire && wstrb_reg[0];

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = addr_hit(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_next = !aw_full_next;
    wready_next = !w_full_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, one cycle answer
  assign ar_fire = s_axi_arvalid && arready_reg;

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    hi_latch_next = hi_latch_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (ar_fire) begin
      rvalid_next = 1'b1;
      rresp_next = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_next = '0;
      if (s_axi_araddr == OFF_CTRL) begin
        rdata_next[6:0] = ctrl_reg;
      end else if (s_axi_araddr == OFF_CNT_LOW) begin
        rdata_next[7:0] = cnt_reg[7:0];
        hi_latch_next = cnt_reg[15:8];
      end else if (s_axi_araddr == OFF_CNT_HIGH) begin
        rdata_next[7:0] = hi_latch_reg;
      end else if (s_axi_araddr == OFF_FLAGS) begin
        rdata_next[3:0] = flags_reg;
      end else if (s_axi_araddr == OFF_IRQ_CTRL) begin
        rdata_next[1:0] = irqc_reg;
      end else if (s_axi_araddr == OFF_CPU_IRQ) begin
        rdata_next[0] = cpu_flag_reg;
      end else begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (s_axi_araddr == 8'(OFF_CH_CTRL + 4 * i)) begin
            rdata_next[5:0] = chc_reg[i];
          end else if (s_axi_araddr == 8'(OFF_CH_VAL + 4 * i)) begin
            rdata_next[15:0] = val_reg[i];
          end
        end
      end
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      hi_latch_reg <= 8'h00;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      hi_latch_reg <= hi_latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, flags and interrupt gating
  assign run_mode = stc_run_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign clr_cnt = wr_lane0 && waddr_reg == OFF_CNT_LOW;
  assign tick_run = tick && run_mode != STC_STOP && !clr_cnt;
  assign flag_set = {ch_evt, tc_evt};
  assign cpu_set = (tc_evt && irqc_reg[IRQC_MASK_BIT]) || |(ch_evt & ch_im);

  always_comb begin
    ctrl_next = ctrl_reg;
    irqc_next = irqc_reg;
    flag_clr = 4'h0;
    cpu_flag_next = cpu_flag_reg;
    if (wr_lane0 && waddr_reg == OFF_CTRL) begin
      ctrl_next = wdata_reg[6:0];
    end else if (wr_lane0 && waddr_reg == OFF_IRQ_CTRL) begin
      irqc_next = wdata_reg[1:0];
    end else if (wr_lane0 && waddr_reg == OFF_FLAGS) begin
      flag_clr = ~wdata_reg[3:0];
    end else if (wr_lane0 && waddr_reg == OFF_CPU_IRQ) begin
      cpu_flag_next = cpu_flag_reg && wdata_reg[0];
    end
    flags_next = (flags_reg & ~flag_clr) | flag_set;
    if (cpu_set) begin
      cpu_flag_next = 1'b1;
    end
    timer_irq_next = cpu_flag_reg && irqc_reg[IRQC_EN_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      irqc_reg <= IRQC_RST;
      flags_reg <= 4'h0;
      cpu_flag_reg <= 1'b0;
      timer_irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      irqc_reg <= irqc_next;
      flags_reg <= flags_next;
      cpu_flag_reg <= cpu_flag_next;
      timer_irq_reg <= timer_irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick source
  stc_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_speed_select(ctrl_reg[CTRL_SPD_LSB +: 3]),
    .tick_prescale_select(ctrl_reg[CTRL_DIV_LSB +: 2]),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter in free, modulo and up/down modes
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    tc_evt = 1'b0;
    if (clr_cnt) begin
      cnt_next = CNT_RST;
      dir_next = STC_DIR_UP;
    end else if (tick_run) begin
      case (run_mode)
        STC_FREE: begin
          cnt_next = 16'(cnt_reg + 16'h0001);
          tc_evt = (cnt_next == CNT_TOP);
        end
        STC_MODULO: begin
          cnt_next = (cnt_reg == val_reg[0]) ? CNT_RST
                                             : 16'(cnt_reg + 16'h0001);
          tc_evt = (cnt_next == val_reg[0]);
        end
        STC_UPDOWN: begin
          if (dir_reg == STC_DIR_UP && cnt_reg < val_reg[0]) begin
            cnt_next = 16'(cnt_reg + 16'h0001);
          end else if (cnt_reg == CNT_RST) begin
            tc_evt = 1'b1;
            dir_next = STC_DIR_UP;
          end else begin
            cnt_next = 16'(cnt_reg - 16'h0001);
            dir_next = STC_DIR_DOWN;
            if (cnt_next == CNT_RST) begin
              tc_evt = 1'b1;
              dir_next = STC_DIR_UP;
            end
          end
        end
        STC_STOP: begin
          cnt_next = cnt_reg;
        end
      endcase
    end
  end

  // Counter registers and pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= CNT_RST;
      dir_reg <= STC_DIR_UP;
      ch_meta_reg <= '0;
      ch_sync_reg <= '0;
      ch_prev_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      ch_meta_reg <= ch_in;
      ch_sync_reg <= ch_meta_reg;
      ch_prev_reg <= ch_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture/compare channels, each with own pin and control
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    logic [5:0] chc_next;
    logic [15:0] val_next;
    logic pin_next, edge_hit, cap_evt, cmp_evt;
    logic [ADDR_W-1:0] ctl_off, val_off;
    assign ctl_off = 8'(OFF_CH_CTRL + 4 * n);
    assign val_off = 8'(OFF_CH_VAL + 4 * n);
    assign ch_im[n] = chc_reg[n][CHC_IM_BIT];
    assign ch_cmp[n] = chc_reg[n][CHC_CMP_BIT];

    // Edge select, compare action and value update
    always_comb begin
      edge_hit = (ch_sync_reg[n] && !ch_prev_reg[n]
                  && chc_reg[n][CHC_EDGE_LSB])
              || (!ch_sync_reg[n] && ch_prev_reg[n]
                  && chc_reg[n][CHC_EDGE_LSB + 1]);
      cap_evt = !ch_cmp[n] && run_mode != STC_STOP && edge_hit;
      cmp_evt = ch_cmp[n] && tick_run && cnt_next == val_reg[n];
      chc_next = chc_reg[n];
      val_next = val_reg[n];
      pin_next = pin_reg[n];
      if (wr_lane0 && waddr_reg == ctl_off) begin
        chc_next = wdata_reg[5:0];
      end
      if (cap_evt) begin
        val_next = cnt_reg;
      end else if (wr_fire && waddr_reg == val_off) begin
        if (wstrb_reg[0]) begin
          val_next[7:0] = wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          val_next[15:8] = wdata_reg[15:8];
        end
      end
      if (cmp_evt) begin
        case (stc_cmp_act_t'(chc_reg[n][CHC_ACT_LSB +: 2]))
          STC_ACT_SET: pin_next = 1'b1;
          STC_ACT_CLR: pin_next = 1'b0;
          STC_ACT_TGL: pin_next = !pin_reg[n];
          STC_ACT_HOLD: pin_next = pin_reg[n];
        endcase
      end
    end

    // Channel 0 in up/down compare flags at the zero turn
    if (n == 0) begin : g_ch0
      assign ch_evt[n] = (run_mode == STC_UPDOWN && ch_cmp[n])
                         ? tc_evt : (cap_evt || cmp_evt);
    end else begin : g_chn
      assign ch_evt[n] = cap_evt || cmp_evt;
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        chc_reg[n] <= CHC_RST;
        val_reg[n] <= VAL_RST;
        pin_reg[n] <= 1'b0;
      end else begin
        chc_reg[n] <= chc_next;
        val_reg[n] <= val_next;
        pin_reg[n] <= pin_next;
      end
    end

    assign ch_out[n] = pin_reg[n];
    assign ch_oe[n] = chc_reg[n][CHC_CMP_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output ports
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign timer_irq = timer_irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_low_write;
    wr_lane0 && waddr_reg == OFF_CNT_LOW;
  endsequence
  sequence s_free_top;
    tick_run && run_mode == STC_FREE && cnt_reg == 16'hFFFE;
  endsequence

  AST_LOW_WRITE_CLEAR: assert property (
    s_low_write |=> cnt_reg == CNT_RST)
    else $error("counter not cleared by low byte write");
  AST_STOP_FREEZE: assert property (
    run_mode == STC_STOP && !clr_cnt |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  AST_FREE_STEP: assert property (
    tick_run && run_mode == STC_FREE |=>
      cnt_reg == 16'($past(cnt_reg) + 16'h0001))
    else $error("free count did not step by one");
  AST_FREE_TC: assert property (
    s_free_top |=> cnt_reg == CNT_TOP && flags_reg[FLAG_TC_BIT])
    else $error("terminal flag missing at top");
  AST_MOD_RELOAD: assert property (
    tick_run && run_mode == STC_MODULO && cnt_reg == val_reg[0]
    |=> cnt_reg == CNT_RST)
    else $error("modulo did not reload zero");
  AST_HI_LATCH: assert property (
    ar_fire && s_axi_araddr == OFF_CNT_LOW
    |=> hi_latch_reg == $past(cnt_reg[15:8]))
    else $error("high byte not latched on low read");
  AST_FLAG_STICKY: assert property (
    flags_reg[FLAG_TC_BIT] && !(wr_lane0 && waddr_reg == OFF_FLAGS)
    |=> flags_reg[FLAG_TC_BIT])
    else $error("terminal flag dropped without clear");
  AST_IRQ_GATE: assert property (
    timer_irq_reg |-> $past(cpu_flag_reg) && $past(irqc_reg[IRQC_EN_BIT]))
    else $error("interrupt without flag and enable");
  AST_CPU_MASK: assert property (
    tc_evt && irqc_reg[IRQC_MASK_BIT] |=> cpu_flag_reg)
    else $error("cpu flag not set by masked event");
  AST_UD_ZERO: assert property (
    tick_run && run_mode == STC_UPDOWN && dir_reg == STC_DIR_DOWN
    && cnt_reg == 16'h0001 |=> cnt_reg == CNT_RST && flags_reg[FLAG_TC_BIT])
    else $error("up/down zero turn not flagged");

endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import stc_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, timer_irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, d, lo, hi;
  logic [1:0] bresp, rresp, rr, br;
  logic [3:0] wstrb;
  logic [NUM_CH-1:0] ch_in, ch_out, ch_oe;
  logic [15:0] va, vb;
  int fail_count, n_compared, cyc, seed, t_ar, ta, tb, per, p;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and cycle count
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  stc_timer u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ch_in(ch_in),
    .ch_out(ch_out), .ch_oe(ch_oe), .timer_irq(timer_irq));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task summarize;
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus master tasks
  task wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    br = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) begin
        arvalid <= 1'b0;
        t_ar = cyc;
      end
    end while (rvalid !== 1'b1);
    q = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task at(input int t);
    while (cyc < t) @(posedge aclk);
  endtask

  // Low byte, pause, then latched high byte
  task samp(input int w, output logic [15:0] v, output int t);
    rd(OFF_CNT_LOW, lo, rr);
    t = t_ar;
    repeat (w) @(posedge aclk);
    rd(OFF_CNT_HIGH, hi, rr);
    v = {hi[7:0], lo[7:0]};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (95000) @(posedge aclk);
    fail_count++;
    summarize;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, ch_in} = 'h0;
    wstrb = 4'hF;
    {cyc, fail_count, n_compared} = 0;
    seed = 32'h5F3E;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFF_CTRL, d, rr);
    chk(d, 32'h0, "ctrl reset");
    rd(8'hFC, d, rr);
    chk(rr, RESP_SLVERR, "unmapped");
    chk(d, 32'h0, "unmapped data");
    wr(8'hFC, 32'hFF);
    chk(br, RESP_SLVERR, "unmapped wr");
    // Tick rate per prescale and speed, model from gap
    for (int i = 0; i < 5; i++) begin
      per = (i == 4) ? 4 : ((i == 0) ? 1 : (1 << (2 * i + 1)));
      wr(OFF_CTRL, (i == 4) ? 32'h21 : ((i << 2) | 1));
      samp(0, va, ta);
      at(ta + 382);
      samp(512, vb, tb);
      chk(vb, 16'(va + (tb - ta) / per), "rate");
    end
    // Stop freezes, low byte write clears
    wr(OFF_CTRL, 32'h0);
    chk(br, RESP_OKAY, "bresp okay");
    samp(0, va, ta);
    samp(40, vb, tb);
    chk(vb, va, "freeze");
    wr(OFF_CNT_LOW, $random(seed));
    samp(0, vb, tb);
    chk(vb, 16'h0, "clear");
    // Free run across the wrap, flags with masks off
    wr(OFF_FLAGS, 32'h0);
    wr(OFF_CTRL, 32'h1);
    samp(0, va, ta);
    rd(OFF_FLAGS, d, rr);
    chk(d, 32'h0, "tc early");
    at(ta + 65600);
    rd(OFF_FLAGS, d, rr);
    chk(d, 32'h1, "tc wrap");
    rd(OFF_CPU_IRQ, d, rr);
    chk(d, 32'h0, "cpu unmasked");
    chk(timer_irq, 1'b0, "irq unmasked");
    samp(0, vb, tb);
    chk(vb, 16'(va + tb - ta), "wrap");
    wr(OFF_FLAGS, 32'h1);
    rd(OFF_FLAGS, d, rr);
    chk(d, 32'h1, "flag keep");
    // Modulo then up/down with all channels and the interrupt
    p = 8 + {$random(seed)} % 32;
    for (int m = 2; m < 4; m++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CH_VAL, p);
      wr(OFF_CH_VAL + 4, p / 2);
      wr(OFF_CH_CTRL, 32'h1);
      wr(OFF_CH_CTRL + 4, (m == 2) ? 32'h1 : 32'h9);
      wr(OFF_CH_CTRL + 8, (m == 2) ? 32'h2 : 32'h6);
      wr(OFF_IRQ_CTRL, 32'h3);
      wr(OFF_CNT_LOW, 32'h0);
      wr(OFF_FLAGS, 32'h0);
      wr(OFF_CPU_IRQ, 32'h0);
      wr(OFF_CTRL, m);
      repeat (4 * p + 8) @(posedge aclk);
      ch_in <= 3'b100;
      for (int k = 0; k < 6; k++) begin
        samp(k, vb, tb);
        chk(vb <= p, 1'b1, "period");
      end
      rd(OFF_FLAGS, d, rr);
      chk(d, 32'hF, "flags");
      rd(OFF_CH_VAL + 8, d, rr);
      chk(d <= p, 1'b1, "capture");
      chk(ch_oe, 3'b011, "oe");
      chk(ch_out[1], m == 2, "cmp action");
      rd(OFF_CPU_IRQ, d, rr);
      chk(d, 32'h1, "cpu masked");
      chk(timer_irq, 1'b1, "irq on");
      wr(OFF_IRQ_CTRL, 32'h1);
      repeat (2) @(posedge aclk);
      chk(timer_irq, 1'b0, "irq off");
      ch_in <= 3'b000;
    end
    summarize;
  end
endmodule
